// >>> core/igdc_defs.svh
// constants of the ion gauge degas control block
`ifndef IGDC_DEFS_SVH
`define IGDC_DEFS_SVH

// timing
`define IGDC_CLK_HZ        25000000
`define IGDC_TICK_US       1000
`define IGDC_TICK_CYC      ((`IGDC_CLK_HZ / 1000000) * `IGDC_TICK_US)
`define IGDC_REM_LOW_MS    25
`define IGDC_REM_HIGH_MS   105
`define IGDC_KEY_DEB_MS    10
`define IGDC_DISP_DLY_MS   2000
`define IGDC_DEGAS_MIN     15
`define IGDC_DEGAS_TO_MS   (`IGDC_DEGAS_MIN * 60000)

// input channel positions
`define IGDC_CH_FIL1       0
`define IGDC_CH_FIL2       1
`define IGDC_CH_DEGAS      2

// register word addresses
`define IGDC_A_CTRL        4'h0
`define IGDC_A_STATUS      4'h1
`define IGDC_A_MASK        4'h2
`define IGDC_A_STATE       4'h3
`define IGDC_A_DEGAS_LIM   4'h4
`define IGDC_A_OVER_LIM    4'h5

// control fields
`define IGDC_CTRL_TO_DIS   0

// event bits of status and mask
`define IGDC_EV_GAUGE_ON   0
`define IGDC_EV_GAUGE_OFF  1
`define IGDC_EV_DEGAS_ON   2
`define IGDC_EV_DEGAS_OFF  3
`define IGDC_EV_DEGAS_TO   4
`define IGDC_EV_OVER       5
`define IGDC_EV_REFUSED    6
`define IGDC_EV_W          7

// reset values
`define IGDC_CTRL_RST      1'h0
`define IGDC_MASK_RST      7'h00
`define IGDC_DEGAS_LIM_RST 16'h4000
`define IGDC_OVER_LIM_RST  16'hc000

`endif

// >>> core/igdc_pkg.sv
// types of the ion gauge degas control block
package igdc_pkg;

	typedef enum logic [1:0] {
		IGDC_OFF   = 2'b00,
		IGDC_ON    = 2'b01,
		IGDC_DEGAS = 2'b10
	} igdc_gauge_t;

	typedef enum logic [0:0] {
		IGDC_R_ARM  = 1'b0,
		IGDC_R_HOLD = 1'b1
	} igdc_rem_t;

endpackage

// >>> core/igdc_key_debounce.sv
// debouncer and press detector for one front panel key
`timescale 1ns/1ps
`include "igdc_defs.svh"

module igdc_key_debounce (
	// clock, reset, millisecond enable
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic tick,
	// key level, high while pressed
	input  wire logic key,
	// one cycle per press
	output logic      press
);

	logic       stable;
	logic [3:0] cnt;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stable <= 1'b0;
			cnt    <= 4'h0;
			press  <= 1'b0;
		end else begin
			press <= 1'b0;
			if (key == stable) begin
				cnt <= 4'h0;
			end else if (tick) begin
				if (cnt == 4'(`IGDC_KEY_DEB_MS - 1)) begin
					cnt    <= 4'h0;
					stable <= key;
					press  <= key;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end

endmodule

// >>> core/igdc_remote_in.sv
// qualifier for one active low remote command input
`timescale 1ns/1ps
`include "igdc_defs.svh"

module igdc_remote_in (
	// clock, reset, millisecond enable
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic tick,
	// remote level, low asserts
	input  wire logic cmd_n,
	// one cycle per accepted low
	output logic      fire
);

	igdc_pkg::igdc_rem_t state;
	logic [6:0]          cnt;

	// a full tick count plus one guarantees the whole hold time
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= igdc_pkg::IGDC_R_ARM;
			cnt   <= 7'h00;
			fire  <= 1'b0;
		end else begin
			fire <= 1'b0;
			case (state)
				igdc_pkg::IGDC_R_ARM: begin
					if (cmd_n) begin
						cnt <= 7'h00;
					end else if (tick) begin
						if (cnt == 7'(`IGDC_REM_LOW_MS)) begin
							cnt   <= 7'h00;
							fire  <= 1'b1;
							state <= igdc_pkg::IGDC_R_HOLD;
						end else begin
							cnt <= cnt + 7'h01;
						end
					end
				end
				igdc_pkg::IGDC_R_HOLD: begin
					if (!cmd_n) begin
						cnt <= 7'h00;
					end else if (tick) begin
						if (cnt == 7'(`IGDC_REM_HIGH_MS)) begin
							cnt   <= 7'h00;
							state <= igdc_pkg::IGDC_R_ARM;
						end else begin
							cnt <= cnt + 7'h01;
						end
					end
				end
				default: begin
					cnt   <= 7'h00;
					state <= igdc_pkg::IGDC_R_HOLD;
				end
			endcase
		end
	end

endmodule

// >>> core/igdc_ctrl.sv
// ion gauge filament and degas control with register port
`timescale 1ns/1ps
`include "igdc_defs.svh"

module igdc_ctrl #(
	parameter int TICK_CYC       = `IGDC_TICK_CYC,
	parameter int DEGAS_TO_TICKS = `IGDC_DEGAS_TO_MS
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// front panel momentary keys, high while pressed
	input  wire logic        key_fil1,
	input  wire logic        key_fil2,
	input  wire logic        key_degas,
	// remote command inputs, low asserts
	input  wire logic        remote_fil1_n,
	input  wire logic        remote_fil2_n,
	input  wire logic        remote_degas_n,
	// pressure from the electrometer, larger code is higher pressure
	input  wire logic [15:0] pressure_code,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// gauge outputs
	output logic             fil1_en,
	output logic             fil2_en,
	output logic             degas_en,
	output logic             degas_led,
	output logic             fil_status,
	output logic             display_valid,
	// interrupt, high while an unmasked status bit is set
	output logic             irq
);

	// millisecond enable
	logic [14:0] tick_cnt;
	logic        tick;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt <= 15'h0000;
			tick     <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (tick_cnt == 15'(TICK_CYC - 1)) begin
				tick_cnt <= 15'h0000;
				tick     <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 15'h0001;
			end
		end
	end

	// command inputs, one channel each for filament 1, filament 2, degas
	logic [2:0] key_v;
	logic [2:0] rem_n_v;
	logic [2:0] key_ev;
	logic [2:0] rem_ev;
	logic [2:0] cmd;

	assign key_v   = {key_degas, key_fil2, key_fil1};
	assign rem_n_v = {remote_degas_n, remote_fil2_n, remote_fil1_n};

	for (genvar i = 0; i < 3; i++) begin : g_in
		igdc_key_debounce u_key (
			.mclk   (mclk),
			.arst_n (arst_n),
			.tick   (tick),
			.key    (key_v[i]),
			.press  (key_ev[i])
		);
		igdc_remote_in u_rem (
			.mclk   (mclk),
			.arst_n (arst_n),
			.tick   (tick),
			.cmd_n  (rem_n_v[i]),
			.fire   (rem_ev[i])
		);
	end

	assign cmd = key_ev | rem_ev;

	// registers
	logic                   ctrl_to_dis;
	logic [`IGDC_EV_W-1:0]  status;
	logic [`IGDC_EV_W-1:0]  mask;
	logic [15:0]            degas_limit;
	logic [15:0]            over_limit;

	// gauge state
	igdc_pkg::igdc_gauge_t  state;
	igdc_pkg::igdc_gauge_t  next_state;
	logic                   fil2_sel;
	logic                   next_fil2_sel;
	logic [19:0]            degas_tmr;
	logic [10:0]            disp_cnt;
	logic                   degas_ok;
	logic                   over_trip;
	logic                   timed_out;
	logic                   refused;
	logic [`IGDC_EV_W-1:0]  ev;

	assign degas_ok = pressure_code < degas_limit;

	assign over_trip = (state != igdc_pkg::IGDC_OFF) && (pressure_code > over_limit);

	assign timed_out = (state == igdc_pkg::IGDC_DEGAS) && !ctrl_to_dis && tick
		&& (degas_tmr == 20'(DEGAS_TO_TICKS - 1));

	always_comb begin
		next_state    = state;
		next_fil2_sel = fil2_sel;
		refused       = 1'b0;
		case (state)
			igdc_pkg::IGDC_OFF: begin
				if (cmd[`IGDC_CH_FIL1]) begin
					next_state    = igdc_pkg::IGDC_ON;
					next_fil2_sel = 1'b0;
				end else if (cmd[`IGDC_CH_FIL2]) begin
					next_state    = igdc_pkg::IGDC_ON;
					next_fil2_sel = 1'b1;
				end else if (cmd[`IGDC_CH_DEGAS]) begin
					refused = 1'b1;
				end
			end
			igdc_pkg::IGDC_ON: begin
				if (over_trip) begin
					next_state = igdc_pkg::IGDC_OFF;
				end else if (cmd[`IGDC_CH_FIL1]) begin
					if (!fil2_sel) begin
						next_state = igdc_pkg::IGDC_OFF;
					end else begin
						next_fil2_sel = 1'b0;
					end
				end else if (cmd[`IGDC_CH_FIL2]) begin
					if (fil2_sel) begin
						next_state = igdc_pkg::IGDC_OFF;
					end else begin
						next_fil2_sel = 1'b1;
					end
				end else if (cmd[`IGDC_CH_DEGAS]) begin
					if (degas_ok) begin
						next_state = igdc_pkg::IGDC_DEGAS;
					end else begin
						refused = 1'b1;
					end
				end
			end
			igdc_pkg::IGDC_DEGAS: begin
				if (over_trip) begin
					next_state = igdc_pkg::IGDC_OFF;
				end else if (cmd[`IGDC_CH_FIL1] || cmd[`IGDC_CH_FIL2]) begin
					next_state = igdc_pkg::IGDC_ON;
				end else if (cmd[`IGDC_CH_DEGAS] || timed_out) begin
					next_state = igdc_pkg::IGDC_ON;
				end
			end
			default: begin
				next_state = igdc_pkg::IGDC_OFF;
			end
		endcase
	end

	// gauge state and filament choice
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= igdc_pkg::IGDC_OFF;
			fil2_sel <= 1'b0;
		end else begin
			state    <= next_state;
			fil2_sel <= next_fil2_sel;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fil1_en <= 1'b0;
			fil2_en <= 1'b0;
		end else begin
			fil1_en <= (next_state != igdc_pkg::IGDC_OFF) && !next_fil2_sel;
			fil2_en <= (next_state != igdc_pkg::IGDC_OFF) && next_fil2_sel;
		end
	end

	// degas power and its lamp
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			degas_en  <= 1'b0;
			degas_led <= 1'b0;
		end else begin
			degas_en  <= next_state == igdc_pkg::IGDC_DEGAS;
			degas_led <= next_state == igdc_pkg::IGDC_DEGAS;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fil_status <= 1'b0;
		end else begin
			fil_status <= next_state != igdc_pkg::IGDC_OFF;
		end
	end

	// degas run time in milliseconds, held at the limit while the timeout is defeated
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			degas_tmr <= 20'h00000;
		end else if (next_state != igdc_pkg::IGDC_DEGAS) begin
			degas_tmr <= 20'h00000;
		end else if (tick && degas_tmr != 20'(DEGAS_TO_TICKS - 1)) begin
			degas_tmr <= degas_tmr + 20'h00001;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			disp_cnt      <= 11'h000;
			display_valid <= 1'b0;
		end else if (next_state == igdc_pkg::IGDC_OFF || state == igdc_pkg::IGDC_OFF
			|| next_fil2_sel != fil2_sel) begin
			disp_cnt      <= 11'h000;
			display_valid <= 1'b0;
		end else if (tick && !display_valid) begin
			if (disp_cnt == 11'(`IGDC_DISP_DLY_MS - 1)) begin
				display_valid <= 1'b1;
			end else begin
				disp_cnt <= disp_cnt + 11'h001;
			end
		end
	end

	// events
	always_comb begin
		ev                     = '0;
		ev[`IGDC_EV_GAUGE_ON]  = (state == igdc_pkg::IGDC_OFF) && (next_state != igdc_pkg::IGDC_OFF);
		ev[`IGDC_EV_GAUGE_OFF] = (state != igdc_pkg::IGDC_OFF) && (next_state == igdc_pkg::IGDC_OFF);
		ev[`IGDC_EV_DEGAS_ON]  = (state != igdc_pkg::IGDC_DEGAS) && (next_state == igdc_pkg::IGDC_DEGAS);
		ev[`IGDC_EV_DEGAS_OFF] = (state == igdc_pkg::IGDC_DEGAS) && (next_state != igdc_pkg::IGDC_DEGAS);
		ev[`IGDC_EV_DEGAS_TO]  = timed_out;
		ev[`IGDC_EV_OVER]      = over_trip;
		ev[`IGDC_EV_REFUSED]   = refused;
	end

	// writable registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_to_dis <= `IGDC_CTRL_RST;
			mask        <= `IGDC_MASK_RST;
			degas_limit <= `IGDC_DEGAS_LIM_RST;
			over_limit  <= `IGDC_OVER_LIM_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`IGDC_A_CTRL:      ctrl_to_dis <= reg_wdata[`IGDC_CTRL_TO_DIS];
				`IGDC_A_MASK:      mask        <= reg_wdata[`IGDC_EV_W-1:0];
				`IGDC_A_DEGAS_LIM: degas_limit <= reg_wdata;
				`IGDC_A_OVER_LIM:  over_limit  <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// sticky status, read clears, a new event wins over the clear
	logic [`IGDC_EV_W-1:0] next_status;

	assign next_status = ((reg_rd && reg_addr == `IGDC_A_STATUS) ? '0 : status) | ev;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// level interrupt from the unmasked sticky bits
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & mask);
		end
	end

	// read data, valid the cycle after the read strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`IGDC_A_CTRL:      reg_rdata <= {15'h0000, ctrl_to_dis};
				`IGDC_A_STATUS:    reg_rdata <= {9'h000, status};
				`IGDC_A_MASK:      reg_rdata <= {9'h000, mask};
				`IGDC_A_STATE:     reg_rdata <= {12'h000, display_valid, fil2_sel, state};
				`IGDC_A_DEGAS_LIM: reg_rdata <= degas_limit;
				`IGDC_A_OVER_LIM:  reg_rdata <= over_limit;
				default:           reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule

// >>> dv/igdc_ctrl_properties.sv
// port assertions of the gauge control block
`timescale 1ns/1ps

module igdc_ctrl_checker #(
	parameter int TICK_CYC       = 25000,
	parameter int DEGAS_TO_TICKS = 900000
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// inputs
	input wire logic [15:0] pressure_code,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	// outputs
	input wire logic [15:0] reg_rdata,
	input wire logic        fil1_en,
	input wire logic        fil2_en,
	input wire logic        degas_en,
	input wire logic        degas_led,
	input wire logic        fil_status,
	input wire logic        display_valid
);
	logic        to_dis;
	logic        fil1_q;
	int unsigned on_cnt;
	int unsigned dg_cnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// timeout disable bit as software wrote it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			to_dis <= 1'b0;
		else if (reg_wr && reg_addr == 4'h0)
			to_dis <= reg_wdata[0];
	end

	// cycles on the same filament, and cycles of timed degas
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt <= 0;
			dg_cnt <= 0;
			fil1_q <= 1'b0;
		end else begin
			fil1_q <= fil1_en;
			on_cnt <= (!(fil1_en || fil2_en) || fil1_en != fil1_q) ? 0 : on_cnt + 1;
			dg_cnt <= (!degas_en || to_dis) ? 0 : dg_cnt + 1;
		end
	end

	a_led_follows_degas: assert property (degas_led == degas_en)
		else $error("degas led differs from degas enable");
	a_one_filament: assert property (!(fil1_en && fil2_en))
		else $error("both filaments enabled");
	a_status_shows_fil: assert property (fil_status == (fil1_en || fil2_en))
		else $error("filament status wrong");
	a_degas_needs_gauge: assert property (degas_en |-> (fil1_en || fil2_en))
		else $error("degas without a filament");
	a_degas_low_press: assert property ($rose(degas_en) |-> $past(pressure_code) < 16'h4000)
		else $error("degas started at high pressure");
	a_over_shuts_off: assert property ((pressure_code > 16'hc000) && (fil1_en || fil2_en)
		|-> ##[1:3] !(fil1_en || fil2_en))
		else $error("overpressure did not shut gauge off");
	a_display_delay: assert property ($rose(display_valid) |-> on_cnt >= 1998 * TICK_CYC)
		else $error("display valid too early");
	a_degas_timeout: assert property (longint'(dg_cnt) <= longint'(DEGAS_TO_TICKS + 2) * TICK_CYC)
		else $error("degas ran past its timeout");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
endmodule

bind igdc_ctrl igdc_ctrl_checker #(.TICK_CYC(TICK_CYC), .DEGAS_TO_TICKS(DEGAS_TO_TICKS)) i_igdc_ctrl_checker (
	.mclk(mclk), .arst_n(arst_n), .pressure_code(pressure_code), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.fil1_en(fil1_en), .fil2_en(fil2_en), .degas_en(degas_en), .degas_led(degas_led),
	.fil_status(fil_status), .display_valid(display_valid));

// >>> dv/igdc_panel_model.sv
// front panel keys and remote contact inputs
`timescale 1ns/1ps

module igdc_panel_model #(
	parameter int TICK_CYC = 4
) (
	// clock
	input  wire logic mclk,
	// front keys, high while pressed
	output logic      key_fil1,
	output logic      key_fil2,
	output logic      key_degas,
	// remote inputs, pulled up when released
	output logic      remote_fil1_n,
	output logic      remote_fil2_n,
	output logic      remote_degas_n
);
	logic [2:0] key_v = 3'h0;
	logic [2:0] rem_v = 3'h7;

	assign key_fil1       = key_v[0];
	assign key_fil2       = key_v[1];
	assign key_degas      = key_v[2];
	assign remote_fil1_n  = rem_v[0];
	assign remote_fil2_n  = rem_v[1];
	assign remote_degas_n = rem_v[2];

	task automatic ms(input int n);
		repeat (n * TICK_CYC) @(posedge mclk);
	endtask

	task automatic press(input int ch);
		@(posedge mclk);
		repeat (2) begin
			key_v[ch] <= 1'b1;
			ms(2);
			key_v[ch] <= 1'b0;
			ms(2);
		end
		key_v[ch] <= 1'b1;
		ms(12);
		key_v[ch] <= 1'b0;
		ms(12);
		#1;
	endtask

	task automatic remote(input int ch, input int low_ms, input int high_ms);
		@(posedge mclk);
		rem_v[ch] <= 1'b0;
		ms(low_ms);
		rem_v[ch] <= 1'b1;
		ms(high_ms);
		#1;
	endtask
endmodule

// >>> dv/igdc_ctrl_tb_top.sv
// self-checking bench of the gauge control block
`timescale 1ns/1ps
`include "igdc_defs.svh"
`define IGDC_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end

module igdc_ctrl_tb_top;
	localparam int TC = 4;
	logic        mclk          = 1'b0;
	logic        arst_n        = 1'b0;
	logic [15:0] pressure_code = 16'h1000;
	logic [3:0]  reg_addr      = 4'h0;
	logic [15:0] reg_wdata     = 16'h0000;
	logic        reg_wr        = 1'b0;
	logic        reg_rd        = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] rd_v;
	logic        k1, k2, kd, r1_n, r2_n, rd_n;
	logic        fil1_en, fil2_en, degas_en, degas_led, fil_status, display_valid, irq;
	logic [4:0]  outs;
	int          fail_count    = 0;
	int          comparisons   = 0;
	int          i;

	assign outs = {fil1_en, fil2_en, degas_en, degas_led, fil_status};
	always #20 mclk = ~mclk;

	igdc_panel_model #(.TICK_CYC(TC)) i_igdc_panel_model (.mclk(mclk), .key_fil1(k1), .key_fil2(k2),
		.key_degas(kd), .remote_fil1_n(r1_n), .remote_fil2_n(r2_n), .remote_degas_n(rd_n));

	igdc_ctrl #(.TICK_CYC(TC), .DEGAS_TO_TICKS(20)) i_igdc_ctrl (.mclk(mclk), .arst_n(arst_n),
		.key_fil1(k1), .key_fil2(k2), .key_degas(kd), .remote_fil1_n(r1_n), .remote_fil2_n(r2_n),
		.remote_degas_n(rd_n), .pressure_code(pressure_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fil1_en(fil1_en), .fil2_en(fil2_en),
		.degas_en(degas_en), .degas_led(degas_led), .fil_status(fil_status),
		.display_valid(display_valid), .irq(irq));

	task automatic ms(input int n);
		repeat (n * TC) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		ms(1);
		`IGDC_CHK(outs, 5'h00)
		rd(4'h3);
		`IGDC_CHK(rd_v, 16'h0000)
		rd(4'h4);
		`IGDC_CHK(rd_v, 16'h4000)
		rd(4'h5);
		`IGDC_CHK(rd_v, 16'hc000)
		rd(4'hf);
		`IGDC_CHK(rd_v, 16'h0000)
		wr(4'h4, 16'h2345);
		wr(4'h5, 16'hb000);
		rd(4'h4);
		`IGDC_CHK(rd_v, 16'h2345)
		rd(4'h5);
		`IGDC_CHK(rd_v, 16'hb000)
		wr(4'h4, 16'h4000);
		wr(4'h5, 16'hc000);
		$display("test reset values done");
		wr(4'h2, 16'h007f);
		i_igdc_panel_model.press(`IGDC_CH_FIL1);
		`IGDC_CHK(outs, 5'h11)
		`IGDC_CHK(irq, 1'b1)
		rd(4'h1);
		`IGDC_CHK(rd_v[0], 1'b1)
		ms(1);
		`IGDC_CHK(irq, 1'b0)
		wr(4'h2, 16'h0000);
		i_igdc_panel_model.press(`IGDC_CH_FIL2);
		`IGDC_CHK(outs, 5'h09)
		`IGDC_CHK(irq, 1'b0)
		ms(1900);
		`IGDC_CHK(display_valid, 1'b0)
		for (i = 0; i < 200 && display_valid !== 1'b1; i++)
			ms(1);
		if (display_valid !== 1'b1) begin
			fail_count++;
			wrap_up();
		end
		$display("test gauge and display done");
		@(posedge mclk) pressure_code <= 16'h5000;
		i_igdc_panel_model.press(`IGDC_CH_DEGAS);
		`IGDC_CHK(outs, 5'h09)
		wr(4'h0, 16'h0001);
		pressure_code <= 16'h1000;
		i_igdc_panel_model.remote(`IGDC_CH_DEGAS, 27, 107);
		`IGDC_CHK(outs, 5'h0f)
		i_igdc_panel_model.press(`IGDC_CH_DEGAS);
		`IGDC_CHK(outs, 5'h09)
		wr(4'h0, 16'h0000);
		i_igdc_panel_model.press(`IGDC_CH_DEGAS);
		`IGDC_CHK(outs, 5'h0f)
		ms(10);
		`IGDC_CHK(outs, 5'h09)
		wr(4'h0, 16'h0001);
		i_igdc_panel_model.press(`IGDC_CH_DEGAS);
		ms(30);
		`IGDC_CHK(outs, 5'h0f)
		i_igdc_panel_model.press(`IGDC_CH_FIL2);
		`IGDC_CHK(outs, 5'h09)
		wr(4'h0, 16'h0000);
		$display("test degas done");
		i_igdc_panel_model.remote(`IGDC_CH_FIL2, 10, 107);
		`IGDC_CHK(outs, 5'h09)
		i_igdc_panel_model.remote(`IGDC_CH_FIL2, 27, 107);
		`IGDC_CHK(outs, 5'h00)
		i_igdc_panel_model.press(`IGDC_CH_FIL1);
		i_igdc_panel_model.press(`IGDC_CH_DEGAS);
		`IGDC_CHK(outs, 5'h17)
		@(posedge mclk) pressure_code <= 16'hd000;
		ms(2);
		`IGDC_CHK(outs, 5'h00)
		@(posedge mclk) pressure_code <= 16'h1000;
		rd(4'h1);
		`IGDC_CHK(rd_v[5], 1'b1)
		`IGDC_CHK(rd_v[4], 1'b1)
		`IGDC_CHK(rd_v[6], 1'b1)
		i_igdc_panel_model.remote(`IGDC_CH_FIL1, 27, 50);
		`IGDC_CHK(outs, 5'h11)
		i_igdc_panel_model.remote(`IGDC_CH_FIL1, 27, 107);
		`IGDC_CHK(outs, 5'h11)
		i_igdc_panel_model.remote(`IGDC_CH_FIL1, 27, 107);
		`IGDC_CHK(outs, 5'h00)
		$display("test remote timing done");
		wrap_up();
	end
endmodule
